// ==== hdl/fvr_once_mem.sv ====
// Small memory holding the eight one-time-programmable phrases.
// Assumes a single clock; read data come out of a register one cycle after the address.
`timescale 1ns/1ps
module fvr_once_mem #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data_q
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [WIDTH-1:0] rd_data_d;

    if (DEPTH < 2 || WIDTH < 1) begin : g_check
        $error("fvr_once_mem: depth must be at least 2");
    end

    always_comb begin
        rd_data_d = mem[rd_idx];
    end

    // Array has no reset: its content is non-volatile by intent
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end
endmodule // fvr_once_mem

// ==== hdl/fvr_pkg.sv ====
// Package for the flash verify / read-once command sequencer.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package fvr_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_INDEX = 8'h04;
    localparam logic [7:0] OFS_PARAM = 8'h08;

    // Status register bit positions
    localparam int BIT_DONE = 7;
    localparam int BIT_ACCESS_ERROR_FLAG = 5;
    localparam int BIT_PVIOL = 4;
    localparam int BIT_MG_HI = 1;
    localparam int BIT_MG_LO = 0;

    // Command codes, upper byte of parameter word 0
    localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
    localparam logic [7:0] CMD_VERIFY_SECTION = 8'h03;
    localparam logic [7:0] CMD_READ_ONCE = 8'h04;

    // Parameter index expected at launch
    localparam logic [2:0] IDX_BLOCK = 3'b001;
    localparam logic [2:0] IDX_SECTION = 3'b010;
    localparam logic [2:0] IDX_READ_ONCE = 3'b001;
    localparam logic [2:0] IDX_RESET = 3'b000;
    localparam int PARAM_WORDS = 6;
    localparam logic [15:0] PARAM_RESET = 16'h0000;

    // Phrase geometry and read-once field
    localparam int PHRASE_SHIFT = 3;
    localparam logic [2:0] PHRASE_ALIGN = 3'b000;
    localparam logic [15:0] ONCE_MAX_INDEX = 16'h0007;
    localparam int ONCE_PHRASES = 8;
    localparam int PHRASE_BITS = 64;
    localparam logic [63:0] ERASED_PHRASE = 64'hFFFF_FFFF_FFFF_FFFF;

    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARRAY = 3'b001,
        ST_ONCE_FETCH = 3'b010,
        ST_ONCE_STORE = 3'b011
    } fvr_state_e;

endpackage

// ==== hdl/fvr_seq.sv ====
// Command sequencer for block verify, section verify and read-once commands.
// Assumes an AHB-Lite master on sys_clk and a flash array port on the same clock.
// Operation
// - Block verify code 0x02, address in words 0-1
// - Launch block verify, check erased, set done
// - Block not erased sets both verify bits
// - Block verify, read-once need index 001
// - Section verify needs index 010
// - Invalid 24-bit address sets access error
// - Read errors set hi, fatal errors lo
// - Section code 0x03, start, phrase count
// - Section verify sets both bits if dirty
// - Misaligned section start sets access error
// - Section past program-flash end is error
// - Mode forbids section or read-once: error
// - Read-once code 0x04, index 0 to 7
// - Read-once phrase lands in words 2-5
// - Read-once index out of range: error
// - Program-flash reads invalid during read-once
// - Illegal command sets error, not processed
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module fvr_seq
    import fvr_pkg::*;
#(
    parameter logic [23:0] PF_BASE = 24'hFE_0000,
    parameter logic [23:0] PF_BYTES = 24'h02_0000,
    parameter logic [23:0] EE_BASE = 24'h10_0000,
    parameter logic [23:0] EE_BYTES = 24'h00_0200
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic arr_req,
    output logic [23:0] arr_addr,
    input wire logic [63:0] arr_rd_data,
    input wire logic arr_valid,
    input wire logic arr_ecc_err,
    input wire logic arr_ecc_fatal,
    input wire logic mode_permit,
    input wire logic once_wr_en,
    input wire logic [2:0] once_wr_idx,
    input wire logic [63:0] once_wr_data,
    output logic pflash_rd_invalid
);
    localparam logic [20:0] PF_PHRASES = PF_BYTES[23:3];
    localparam logic [20:0] EE_PHRASES = EE_BYTES[23:3];

    if (PF_BYTES[2:0] != 3'b000 || EE_BYTES[2:0] != 3'b000 || PF_PHRASES == 21'd0
            || EE_PHRASES == 21'd0) begin : g_check
        $error("fvr_seq: flash sizes must be whole nonzero phrases");
    end

    function automatic logic in_range(input logic [23:0] a, input logic [23:0] base,
                                      input logic [23:0] bytes);
        logic [24:0] lim;
        lim = {1'b0, base} + {1'b0, bytes};
        in_range = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < lim);
    endfunction

    fvr_state_e state_q, state_d;
    logic done_q, done_d;
    logic access_error_flag_q, access_error_flag_d;
    logic mg_hi_q, mg_hi_d;
    logic mg_lo_q, mg_lo_d;
    logic [2:0] index_q, index_d;
    logic [15:0] params_q [0:PARAM_WORDS-1];
    logic [15:0] params_d [0:PARAM_WORDS-1];
    logic [23:0] cur_addr_q, cur_addr_d;
    logic [20:0] remain_q, remain_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_ofs_q, wr_ofs_d;
    logic mode_meta_q, mode_sync_q;
    logic [63:0] once_rd_data;

    logic accept;
    logic [7:0] cmd_code;
    logic [23:0] cmd_addr;
    logic [24:0] sect_end;
    logic [24:0] pf_end;
    logic launch;
    logic launch_err;
    logic [31:0] status_word;

    fvr_once_mem #(
        .WIDTH(PHRASE_BITS),
        .DEPTH(ONCE_PHRASES)
    ) u_once (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wr_en(once_wr_en),
        .wr_idx(once_wr_idx),
        .wr_data(once_wr_data),
        .rd_idx(params_q[1][2:0]),
        .rd_data_q(once_rd_data)
    );

    // Zero-wait slave: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign arr_req = (state_q == ST_ARRAY);
    assign arr_addr = cur_addr_q;
    assign pflash_rd_invalid = (state_q == ST_ONCE_FETCH) || (state_q == ST_ONCE_STORE);

    assign accept = hsel && hready && htrans[1];
    assign cmd_code = params_q[0][15:8];
    assign cmd_addr = {params_q[0][7:0], params_q[1]};
    assign sect_end = {1'b0, cmd_addr} + {6'b00_0000, params_q[2], 3'b000};
    assign pf_end = {1'b0, PF_BASE} + {1'b0, PF_BYTES};

    // Protection violation never set by these commands
    always_comb begin
        status_word = '0;
        status_word[BIT_DONE] = done_q;
        status_word[BIT_ACCESS_ERROR_FLAG] = access_error_flag_q;
        status_word[BIT_PVIOL] = 1'b0;
        status_word[BIT_MG_HI] = mg_hi_q;
        status_word[BIT_MG_LO] = mg_lo_q;
    end

    // Launch takes the pre-write flags: a write clearing errors cannot also launch
    assign launch = wr_pend_q && (wr_ofs_q == OFS_STATUS) && hwdata[BIT_DONE] && done_q
                    && !access_error_flag_q;

    always_comb begin
        launch_err = 1'b1;
        unique case (cmd_code)
            CMD_VERIFY_BLOCK: begin
                launch_err = (index_q != IDX_BLOCK)
                    || !(in_range(cmd_addr, PF_BASE, PF_BYTES)
                    || in_range(cmd_addr, EE_BASE, EE_BYTES));
            end
            CMD_VERIFY_SECTION: begin
                launch_err = (index_q != IDX_SECTION)
                    || !mode_sync_q
                    || !in_range(cmd_addr, PF_BASE, PF_BYTES)
                    || (cmd_addr[2:0] != PHRASE_ALIGN)
                    || (params_q[2] == 16'h0000)
                    || (sect_end > pf_end);
            end
            CMD_READ_ONCE: begin
                launch_err = (index_q != IDX_READ_ONCE)
                    || !mode_sync_q
                    || (params_q[1] > ONCE_MAX_INDEX);
            end
            default: begin
                launch_err = 1'b1;
            end
        endcase
    end

    always_comb begin
        state_d = state_q;
        done_d = done_q;
        access_error_flag_d = access_error_flag_q;
        mg_hi_d = mg_hi_q;
        mg_lo_d = mg_lo_q;
        index_d = index_q;
        params_d = params_q;
        cur_addr_d = cur_addr_q;
        remain_d = remain_q;
        wr_pend_d = accept && hwrite && (hsize == HSIZE_WORD);
        wr_ofs_d = haddr[7:0];
        hrdata_d = hrdata_q;

        if (accept && !hwrite) begin
            unique case (haddr[7:0])
                OFS_STATUS: hrdata_d = status_word;
                OFS_INDEX: hrdata_d = {29'h0000_0000, index_q};
                OFS_PARAM: hrdata_d = (index_q < 3'(PARAM_WORDS)) ?
                                      {16'h0000, params_q[index_q]} : HRDATA_RESET;
                default: hrdata_d = HRDATA_RESET;
            endcase
        end

        // Software writes; parameters are frozen while a command runs
        if (wr_pend_q) begin
            unique case (wr_ofs_q)
                OFS_STATUS: begin
                    if (hwdata[BIT_ACCESS_ERROR_FLAG]) begin
                        access_error_flag_d = 1'b0;
                    end
                end
                OFS_INDEX: begin
                    if (done_q) begin
                        index_d = hwdata[2:0];
                    end
                end
                OFS_PARAM: begin
                    if (done_q && index_q < 3'(PARAM_WORDS)) begin
                        params_d[index_q] = hwdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (launch) begin
            mg_hi_d = 1'b0;
            mg_lo_d = 1'b0;
            if (launch_err) begin
                access_error_flag_d = 1'b1;
            end else begin
                done_d = 1'b0;
                unique case (cmd_code)
                    CMD_VERIFY_BLOCK: begin
                        state_d = ST_ARRAY;
                        if (in_range(cmd_addr, PF_BASE, PF_BYTES)) begin
                            cur_addr_d = PF_BASE;
                            remain_d = PF_PHRASES;
                        end else begin
                            cur_addr_d = EE_BASE;
                            remain_d = EE_PHRASES;
                        end
                    end
                    CMD_VERIFY_SECTION: begin
                        state_d = ST_ARRAY;
                        cur_addr_d = cmd_addr;
                        remain_d = {5'b0_0000, params_q[2]};
                    end
                    default: begin
                        state_d = ST_ONCE_FETCH;
                    end
                endcase
            end
        end

        unique case (state_q)
            ST_IDLE: begin
            end
            ST_ARRAY: begin
                if (arr_valid) begin
                    if (arr_ecc_err) begin
                        mg_hi_d = 1'b1;
                    end
                    if (arr_ecc_fatal) begin
                        mg_lo_d = 1'b1;
                    end
                    if (arr_rd_data != ERASED_PHRASE) begin
                        mg_hi_d = 1'b1;
                        mg_lo_d = 1'b1;
                    end
                    cur_addr_d = cur_addr_q + 24'(1 << PHRASE_SHIFT);
                    remain_d = remain_q - 21'd1;
                    if (remain_q == 21'd1) begin
                        state_d = ST_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            ST_ONCE_FETCH: begin
                // Memory output register is valid one cycle after the index
                state_d = ST_ONCE_STORE;
            end
            ST_ONCE_STORE: begin
                params_d[2] = once_rd_data[63:48];
                params_d[3] = once_rd_data[47:32];
                params_d[4] = once_rd_data[31:16];
                params_d[5] = once_rd_data[15:0];
                state_d = ST_IDLE;
                done_d = 1'b1;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_meta_q <= 1'b0;
            mode_sync_q <= 1'b0;
        end else begin
            mode_meta_q <= mode_permit;
            mode_sync_q <= mode_meta_q;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
            access_error_flag_q <= 1'b0;
            mg_hi_q <= 1'b0;
            mg_lo_q <= 1'b0;
            index_q <= IDX_RESET;
            for (int i = 0; i < PARAM_WORDS; i++) begin
                params_q[i] <= PARAM_RESET;
            end
            cur_addr_q <= '0;
            remain_q <= '0;
            hrdata_q <= HRDATA_RESET;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= '0;
        end else begin
            state_q <= state_d;
            done_q <= done_d;
            access_error_flag_q <= access_error_flag_d;
            mg_hi_q <= mg_hi_d;
            mg_lo_q <= mg_lo_d;
            index_q <= index_d;
            params_q <= params_d;
            cur_addr_q <= cur_addr_d;
            remain_q <= remain_d;
            hrdata_q <= hrdata_d;
            wr_pend_q <= wr_pend_d;
            wr_ofs_q <= wr_ofs_d;
        end
    end
endmodule // fvr_seq

// ==== sim/flash_verify_read_once_cmds_bench.sv ====
// Self-checking bench for the verify and read-once sequencer.
// Assumes fvr_pkg, fvr_seq and fvr_chk compiled first; the bench plays bus and array.
`timescale 1ns/1ps
module flash_verify_read_once_cmds_bench
    import fvr_pkg::*;
;
    localparam logic [7:0] VB = CMD_VERIFY_BLOCK;
    localparam logic [7:0] VS = CMD_VERIFY_SECTION;
    localparam logic [7:0] RO = CMD_READ_ONCE;
    // Flash map given to the design; small program block keeps scans short
    localparam logic [23:0] PF_B = 24'hFE_0000;
    localparam logic [23:0] PF_N = 24'h00_0040;
    localparam logic [23:0] EE_B = 24'h10_0000;
    localparam logic [23:0] EE_N = 24'h00_0200;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0, arr_valid = 1'b0, arr_ecc_err = 1'b0, arr_ecc_fatal = 1'b0;
    logic mode_permit = 1'b0, once_wr_en = 1'b0;
    logic [2:0] once_wr_idx = 3'h0;
    logic [63:0] once_wr_data = 64'h0000_0000_0000_0000, arr_rd_data = ERASED_PHRASE;
    logic hreadyout, hresp, arr_req, pflash_rd_invalid;
    logic [31:0] hrdata;
    logic [23:0] arr_addr;
    logic [63:0] once_mem [8];
    logic [1:0] flt = 2'h0;
    int n_errors = 0, n_tests = 0;
    int n_phr = 0;
    logic [23:0] last_addr = 24'h00_0000;

    fvr_seq #(.PF_BASE(PF_B), .PF_BYTES(PF_N), .EE_BASE(EE_B), .EE_BYTES(EE_N)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .arr_req(arr_req), .arr_addr(arr_addr), .arr_rd_data(arr_rd_data),
        .arr_valid(arr_valid), .arr_ecc_err(arr_ecc_err), .arr_ecc_fatal(arr_ecc_fatal),
        .mode_permit(mode_permit), .once_wr_en(once_wr_en), .once_wr_idx(once_wr_idx),
        .once_wr_data(once_wr_data), .pflash_rd_invalid(pflash_rd_invalid));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // Array side answers at a random pace; fault kind set per test
    always @(posedge sys_clk) begin
        arr_valid <= arr_req && $urandom_range(1) == 1;
        arr_rd_data <= (flt == 2'h1) ? 64'h0000_0000_0000_FFFF : ERASED_PHRASE;
        arr_ecc_err <= flt[1];
        arr_ecc_fatal <= flt == 2'h3;
        // Tally consumed phrases so scan length and end point can be checked
        if (arr_req && arr_valid) begin
            n_phr <= n_phr + 1;
            last_addr <= arr_addr;
        end
    end

    // {phrase count, last phrase address} of a clean verify scan
    function automatic logic [47:0] scan_exp(input logic [7:0] code, input logic [23:0] a,
            input logic [15:0] n);
        logic [23:0] base;
        logic [23:0] cnt;
        base = (a >= EE_B && a < EE_B + EE_N) ? EE_B : PF_B;
        cnt = (a >= EE_B && a < EE_B + EE_N) ? (EE_N >> 3) : (PF_N >> 3);
        if (code == VS) begin
            base = a;
            cnt = {8'h00, n};
        end
        scan_exp = {cnt, base + ((cnt - 24'h00_0001) << 3)};
    endfunction

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // e = {access error, verify hi, verify lo} expected after the command
    task automatic run(input logic [7:0] code, input logic [7:0] ahi, input logic [15:0] w1,
            input logic [15:0] w2, input int idx, input logic perm, input logic [1:0] f,
            input logic [2:0] e);
        logic [31:0] q;
        logic [15:0] w [3];
        int n0;
        logic [47:0] se;
        w[0] = {code, ahi};
        w[1] = w1;
        w[2] = w2;
        flt = f;
        mode_permit <= perm;
        bus(1'b1, OFS_STATUS, 32'h0000_0020, q);
        for (int i = 0; i <= idx; i++) begin
            bus(1'b1, OFS_INDEX, 32'(i), q);
            bus(1'b1, OFS_PARAM, {16'h0000, w[i]}, q);
        end
        n0 = n_phr;
        se = scan_exp(code, {ahi, w1}, w2);
        // Refused commands and read-once must not touch the array
        if (code == RO || e[2]) begin
            se[47:24] = 24'h00_0000;
        end
        bus(1'b1, OFS_STATUS, 32'h0000_0080, q);
        @(posedge sys_clk);
        q = 32'h0000_0000;
        for (int k = 0; k < 300 && q[BIT_DONE] !== 1'b1; k++) begin
            bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
        end
        chk(q, {24'h00_0000, 2'h2, e[2], 3'h0, e[1:0]});
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
        chk(32'(n_phr - n0), {8'h00, se[47:24]});
        if (se[47:24] != 24'h00_0000) begin
            chk({8'h00, last_addr}, {8'h00, se[23:0]});
        end
        if (code == RO && e == 3'h0) begin
            for (int i = 2; i < 6; i++) begin
                bus(1'b1, OFS_INDEX, 32'(i), q);
                bus(1'b0, OFS_PARAM, 32'h0000_0000, q);
                chk(q, {16'h0000, once_mem[w1[2:0]][16 * (5 - i) +: 16]});
            end
        end
        $display("test code %h idx %0d done", code, idx);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_errors++;
        results();
    end

    initial begin
        logic [15:0] ix;
        void'($urandom(55156));
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < ONCE_PHRASES; i++) begin
            once_mem[i] = {$urandom, $urandom};
            once_wr_en <= 1'b1;
            once_wr_idx <= 3'(i);
            once_wr_data <= once_mem[i];
            @(posedge sys_clk);
        end
        once_wr_en <= 1'b0;
        ix = 16'($urandom_range(7));
        run(VB, 8'hFE, 16'h0010, 16'h0000, 1, 1'b1, 2'h0, 3'h0);
        run(VB, 8'hFE, 16'h0000, 16'h0000, 1, 1'b0, 2'h1, 3'h3);
        run(VB, 8'h10, 16'h0100, 16'h0000, 1, 1'b1, 2'h2, 3'h2);
        run(VB, 8'h10, 16'h0000, 16'h0000, 1, 1'b1, 2'h3, 3'h3);
        run(VB, 8'hFE, 16'h0000, 16'h0000, 2, 1'b1, 2'h0, 3'h4);
        run(VB, 8'h50, 16'h0000, 16'h0000, 1, 1'b1, 2'h0, 3'h4);
        run(VS, 8'hFE, 16'h0008, 16'h0004, 2, 1'b1, 2'h0, 3'h0);
        run(VS, 8'hFE, 16'h0038, 16'h0001, 2, 1'b1, 2'h1, 3'h3);
        run(VS, 8'hFE, 16'h0000, 16'h0001, 1, 1'b1, 2'h0, 3'h4);
        run(VS, 8'hFE, 16'h0004, 16'h0001, 2, 1'b1, 2'h0, 3'h4);
        run(VS, 8'hFE, 16'h0020, 16'h0005, 2, 1'b1, 2'h0, 3'h4);
        run(VS, 8'hFE, 16'h0000, 16'h0001, 2, 1'b0, 2'h0, 3'h4);
        run(RO, 8'h00, ix, 16'h0000, 1, 1'b1, 2'h0, 3'h0);
        run(RO, 8'h00, 16'h0007, 16'h0000, 1, 1'b1, 2'h0, 3'h0);
        run(RO, 8'h00, 16'h0008, 16'h0000, 1, 1'b1, 2'h0, 3'h4);
        run(RO, 8'h00, 16'h0003, 16'h0000, 1, 1'b0, 2'h0, 3'h4);
        run(RO, 8'h00, 16'h0003, 16'h0000, 2, 1'b1, 2'h0, 3'h4);
        run(8'h09, 8'hFE, 16'h0000, 16'h0000, 1, 1'b1, 2'h0, 3'h4);
        results();
    end
endmodule // flash_verify_read_once_cmds_bench

bind fvr_seq fvr_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .arr_req(arr_req),
    .arr_addr(arr_addr), .arr_valid(arr_valid), .pflash_rd_invalid(pflash_rd_invalid));

// ==== sim/fvr_chk.sv ====
// Checker for the verify and read-once sequencer, bound to fvr_seq.
// Assumes one clock, zero-wait-state bus and hready tied to hreadyout.
`timescale 1ns/1ps
module fvr_chk
    import fvr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic arr_req,
    input wire logic [23:0] arr_addr,
    input wire logic arr_valid,
    input wire logic pflash_rd_invalid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic take_st;
    logic st_wr_q;
    logic st_wr_d;
    logic st_rd_q;
    logic st_rd_d;

    // Status data phase in flight, so launches can be tied to their write
    assign take_st = hsel && htrans[1] && haddr[7:0] == OFS_STATUS;

    always_comb begin
        st_wr_d = st_wr_q;
        st_rd_d = st_rd_q;
        if (hready) begin
            st_wr_d = take_st && hwrite;
            st_rd_d = take_st && !hwrite;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_wr_q <= 1'b0;
            st_rd_q <= 1'b0;
        end else begin
            st_wr_q <= st_wr_d;
            st_rd_q <= st_rd_d;
        end
    end

    chk_addr_step: assert property (
        arr_req && arr_valid |=> !arr_req || arr_addr == $past(arr_addr) + 24'h00_0008)
        else $error("array address did not advance by one phrase");
    chk_addr_hold: assert property (arr_req && !arr_valid |=> arr_req && $stable(arr_addr))
        else $error("array request dropped or moved without a phrase");
    chk_start_aligned: assert property ($rose(arr_req) |-> arr_addr[2:0] == PHRASE_ALIGN)
        else $error("array scan started off a phrase boundary");
    chk_launch_arr: assert property ($rose(arr_req) |-> $past(st_wr_q))
        else $error("array scan began without a status write");
    chk_launch_once: assert property ($rose(pflash_rd_invalid) |-> $past(st_wr_q))
        else $error("read-once began without a status write");
    chk_once_len: assert property (
        $rose(pflash_rd_invalid) |-> pflash_rd_invalid [*2] ##1 !pflash_rd_invalid)
        else $error("read-once busy window not two cycles");
    chk_once_excl: assert property (pflash_rd_invalid |-> !arr_req)
        else $error("array scan overlaps read-once");
    chk_scan_bound: assert property ($rose(arr_req) |-> ##[1:300] !arr_req)
        else $error("array scan never finished");
    chk_pviol_zero: assert property (st_rd_q |-> !hrdata[BIT_PVIOL])
        else $error("protection violation flag seen set");

    cover property ($rose(arr_req));
    cover property ($rose(pflash_rd_invalid));
    cover property (st_rd_q && hrdata[BIT_ACCESS_ERROR_FLAG]);
endmodule // fvr_chk
